/* hdl/xtad_pkg.sv */
package xtad_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_INSTR = 5'h00;
	localparam logic [4:0] OFS_OPA = 5'h04;
	localparam logic [4:0] OFS_OPB = 5'h08;
	localparam logic [4:0] OFS_FLAGS = 5'h0C;
	localparam logic [4:0] OFS_STATUS = 5'h10;
	localparam logic [4:0] OFS_RESULT = 5'h14;
	localparam logic [4:0] OFS_SEG = 5'h18;
	localparam logic [15:0] FLAGS_RST = 16'h0000;
	// Flag word bit positions
	localparam int FL_C = 0;
	localparam int FL_P = 2;
	localparam int FL_A = 4;
	localparam int FL_Z = 6;
	localparam int FL_S = 7;
	localparam int FL_O = 11;
	// INSTR register fields
	localparam int INSTR_ODD = 16;
	// Opcodes
	localparam logic [7:0] OP_OFFS_LOAD = 8'h8D;
	localparam logic [7:0] OP_FAR_DS = 8'hC5;
	localparam logic [7:0] OP_FAR_ES = 8'hC4;
	localparam logic [7:0] OP_FL_STORE = 8'h9C;
	localparam logic [7:0] OP_FL_RESTORE = 8'h9D;
	localparam logic [7:0] OP_UBCD = 8'h37;
	localparam logic [7:0] OP_PBCD = 8'h27;
	localparam logic [5:0] PFX_ADD_RM = 6'h00;
	localparam logic [5:0] PFX_ADC_RM = 6'h04;
	localparam logic [5:0] PFX_SUB_RM = 6'h0A;
	localparam logic [5:0] PFX_IMM = 6'h20;
	localparam logic [6:0] PFX_ADD_ACC = 7'h02;
	localparam logic [6:0] PFX_ADC_ACC = 7'h0A;
	localparam logic [6:0] PFX_SUB_ACC = 7'h16;
	localparam logic [6:0] PFX_INC_RM = 7'h7F;
	localparam logic [4:0] PFX_INC_REG = 5'h08;
	localparam logic [2:0] MID_ADD = 3'h0;
	localparam logic [2:0] MID_ADC = 3'h2;
	localparam logic [2:0] MID_SUB = 3'h5;
	localparam logic [2:0] MID_INC = 3'h0;
	localparam logic [1:0] MOD_REG = 2'h3;
	// Base clocks per form
	localparam logic [7:0] CLK_OFFS_LOAD = 8'h02;
	localparam logic [7:0] CLK_FAR = 8'h10;
	localparam logic [7:0] CLK_FL_STORE = 8'h0A;
	localparam logic [7:0] CLK_FL_RESTORE = 8'h08;
	localparam logic [7:0] CLK_RR = 8'h03;
	localparam logic [7:0] CLK_M2R = 8'h09;
	localparam logic [7:0] CLK_R2M = 8'h10;
	localparam logic [7:0] CLK_IMM_REG = 8'h04;
	localparam logic [7:0] CLK_IMM_MEM = 8'h11;
	localparam logic [7:0] CLK_ACC = 8'h04;
	localparam logic [7:0] CLK_INC_REG = 8'h02;
	localparam logic [7:0] CLK_INC_MEM = 8'h0F;
	localparam logic [7:0] CLK_BCD = 8'h04;
	localparam logic [7:0] CLK_ODD_WORD = 8'h04;
	// Operand-offset clocks
	localparam logic [7:0] EA_DIRECT = 8'h06;
	localparam logic [7:0] EA_BASE = 8'h05;
	localparam logic [7:0] EA_BASE_DISP = 8'h09;
	localparam logic [7:0] EA_BI_FAST = 8'h07;
	localparam logic [7:0] EA_BI_SLOW = 8'h08;
	localparam logic [7:0] EA_BI_FAST_DISP = 8'h0B;
	localparam logic [7:0] EA_BI_SLOW_DISP = 8'h0C;
	localparam logic [3:0] BCD_NINE = 4'h9;
	localparam logic [7:0] BCD_LOW_FIX = 8'h06;
	localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
	localparam logic [7:0] BCD_HIGH_LIM = 8'h99;

	typedef enum logic [4:0] {
		CL_NONE, CL_OFFS_LOAD, CL_FAR_DS, CL_FAR_ES, CL_FL_STORE, CL_FL_RESTORE,
		CL_ADD, CL_ADC, CL_SUB, CL_INC, CL_UBCD, CL_PBCD
	} xtad_class_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} xtad_state_t;
endpackage

/* hdl/xtad_ea_time.sv */
`timescale 1ns/1ps
module xtad_ea_time (
	input wire logic [7:0] i_modrm,
	output logic [7:0] o_ea_clk,
	output logic [1:0] o_disp_bytes,
	output logic o_is_reg
);
	logic [1:0] mode;
	logic [2:0] sel;
	logic slow;
	logic pair;
	assign mode = i_modrm[7:6];
	assign sel = i_modrm[2:0];
	assign pair = ~sel[2];
	assign slow = sel[1] ^ sel[0];

	always_comb
	begin
		o_is_reg = 1'b0;
		o_disp_bytes = 2'h0;
		o_ea_clk = 8'h00;
		unique case (mode)
			2'h0:
			begin
				if (sel == 3'h6)
				begin
					o_disp_bytes = 2'h2;
					o_ea_clk = xtad_pkg::EA_DIRECT;
				end
				else
				begin
					o_ea_clk = pair ? (slow ? xtad_pkg::EA_BI_SLOW : xtad_pkg::EA_BI_FAST)
						: xtad_pkg::EA_BASE;
				end
			end
			2'h1, 2'h2:
			begin
				o_disp_bytes = (mode == 2'h1) ? 2'h1 : 2'h2;
				o_ea_clk = pair ? (slow ? xtad_pkg::EA_BI_SLOW_DISP : xtad_pkg::EA_BI_FAST_DISP)
					: xtad_pkg::EA_BASE_DISP;
			end
			2'h3:
				o_is_reg = 1'b1;
		endcase
	end
endmodule

/* hdl/xtad_decode.sv */
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module xtad_decode #(
	parameter int DATA_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_busy
);
	typedef struct packed {
		logic [DATA_W:0] sum;
		logic c;
		logic a;
		logic o;
	} xtad_alu_t;

	typedef struct packed {
		xtad_pkg::xtad_class_t cls;
		logic wide;
		logic dir;
		logic mem;
		logic legal;
		logic [1:0] data_bytes;
		logic [7:0] clk;
	} xtad_dec_t;

	typedef struct packed {
		xtad_pkg::xtad_state_t fsm;
		logic bus_wait;
		logic [31:0] rdata;
		logic [16:0] instr;
		logic [DATA_W-1:0] opa;
		logic [DATA_W-1:0] opb;
		logic [DATA_W-1:0] flags;
		logic [DATA_W-1:0] result;
		logic [DATA_W-1:0] seg;
		logic seg_extra;
		xtad_dec_t dec;
		logic [7:0] cnt;
		logic [DATA_W-1:0] pend_res;
		logic [DATA_W-1:0] pend_flags;
		logic done;
		logic refused;
	} xtad_st_t;

	xtad_st_t st;
	xtad_st_t next_st;
	logic [7:0] ea_clk;
	logic [1:0] disp_bytes;
	logic is_reg;

	xtad_ea_time u_ea (
		.i_modrm(i_writedata[15:8]),
		.o_ea_clk(ea_clk),
		.o_disp_bytes(disp_bytes),
		.o_is_reg(is_reg)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (be[i])
				r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	// Add or subtract with carry, byte or word
	function automatic xtad_alu_t arith(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
		input logic cin, input logic sub, input logic wide);
		xtad_alu_t r;
		logic [DATA_W-1:0] bb;
		logic ci;
		bb = sub ? ~b : b;
		ci = sub ? ~cin : cin;
		r.sum = {1'b0, a} + {1'b0, bb} + {{DATA_W{1'b0}}, ci};
		if (wide)
		begin
			r.c = r.sum[DATA_W] ^ sub;
			r.o = (a[DATA_W-1] == bb[DATA_W-1]) && (r.sum[DATA_W-1] != a[DATA_W-1]);
		end
		else
		begin
			r.c = (a[8] ^ bb[8] ^ r.sum[8]) ^ sub;
			r.o = (a[7] == bb[7]) && (r.sum[7] != a[7]);
			r.sum[DATA_W:8] = '0;
		end
		r.a = a[4] ^ b[4] ^ r.sum[4];
		return r;
	endfunction

	// Sign, zero and parity into a flag word
	function automatic logic [DATA_W-1:0] szp(input logic [DATA_W-1:0] f,
		input logic [DATA_W-1:0] res, input logic wide);
		logic [DATA_W-1:0] r;
		r = f;
		r[xtad_pkg::FL_S] = wide ? res[DATA_W-1] : res[7];
		r[xtad_pkg::FL_Z] = wide ? (res == '0) : (res[7:0] == 8'h00);
		r[xtad_pkg::FL_P] = ~^res[7:0];
		return r;
	endfunction

	function automatic xtad_dec_t decode(input logic [7:0] op, input logic [7:0] modrm,
		input logic [7:0] ea, input logic reg_form, input logic odd);
		xtad_dec_t d;
		logic [7:0] mem_ea;
		d.cls = xtad_pkg::CL_NONE;
		d.wide = op[0];
		d.dir = op[1];
		d.mem = ~reg_form;
		d.legal = 1'b1;
		d.data_bytes = 2'h0;
		d.clk = 8'h00;
		mem_ea = ea + ((op[0] && odd) ? xtad_pkg::CLK_ODD_WORD : 8'h00);
		if (op == xtad_pkg::OP_OFFS_LOAD)
		begin
			d.cls = xtad_pkg::CL_OFFS_LOAD;
			d.wide = 1'b1;
			d.clk = xtad_pkg::CLK_OFFS_LOAD + ea;
		end
		else if (op == xtad_pkg::OP_FAR_DS || op == xtad_pkg::OP_FAR_ES)
		begin
			d.cls = op[0] ? xtad_pkg::CL_FAR_DS : xtad_pkg::CL_FAR_ES;
			d.wide = 1'b1;
			d.clk = xtad_pkg::CLK_FAR + ea + ((odd && !reg_form) ? xtad_pkg::CLK_ODD_WORD : 8'h00);
		end
		else if (op == xtad_pkg::OP_FL_STORE || op == xtad_pkg::OP_FL_RESTORE)
		begin
			d.cls = op[0] ? xtad_pkg::CL_FL_RESTORE : xtad_pkg::CL_FL_STORE;
			d.wide = 1'b1;
			d.mem = 1'b0;
			d.clk = op[0] ? xtad_pkg::CLK_FL_RESTORE : xtad_pkg::CLK_FL_STORE;
		end
		else if (op == xtad_pkg::OP_UBCD || op == xtad_pkg::OP_PBCD)
		begin
			d.cls = (op == xtad_pkg::OP_UBCD) ? xtad_pkg::CL_UBCD : xtad_pkg::CL_PBCD;
			d.wide = 1'b0;
			d.mem = 1'b0;
			d.clk = xtad_pkg::CLK_BCD;
		end
		else if (op[7:2] == xtad_pkg::PFX_ADD_RM || op[7:2] == xtad_pkg::PFX_ADC_RM
			|| op[7:2] == xtad_pkg::PFX_SUB_RM)
		begin
			d.cls = (op[7:2] == xtad_pkg::PFX_ADD_RM) ? xtad_pkg::CL_ADD
				: (op[7:2] == xtad_pkg::PFX_ADC_RM) ? xtad_pkg::CL_ADC : xtad_pkg::CL_SUB;
			d.clk = reg_form ? xtad_pkg::CLK_RR
				: (op[1] ? xtad_pkg::CLK_M2R : xtad_pkg::CLK_R2M) + mem_ea;
		end
		else if (op[7:2] == xtad_pkg::PFX_IMM)
		begin
			d.dir = 1'b0;
			d.data_bytes = (op[1:0] == 2'h1) ? 2'h2 : 2'h1;
			unique case (modrm[5:3])
				xtad_pkg::MID_ADD: d.cls = xtad_pkg::CL_ADD;
				xtad_pkg::MID_ADC: d.cls = xtad_pkg::CL_ADC;
				xtad_pkg::MID_SUB: d.cls = xtad_pkg::CL_SUB;
				default: d.legal = 1'b0;
			endcase
			d.clk = reg_form ? xtad_pkg::CLK_IMM_REG : xtad_pkg::CLK_IMM_MEM + mem_ea;
		end
		else if (op[7:1] == xtad_pkg::PFX_ADD_ACC || op[7:1] == xtad_pkg::PFX_ADC_ACC
			|| op[7:1] == xtad_pkg::PFX_SUB_ACC)
		begin
			d.cls = (op[7:1] == xtad_pkg::PFX_ADD_ACC) ? xtad_pkg::CL_ADD
				: (op[7:1] == xtad_pkg::PFX_ADC_ACC) ? xtad_pkg::CL_ADC : xtad_pkg::CL_SUB;
			d.mem = 1'b0;
			d.dir = 1'b1;
			d.data_bytes = op[0] ? 2'h2 : 2'h1;
			d.clk = xtad_pkg::CLK_ACC;
		end
		else if (op[7:1] == xtad_pkg::PFX_INC_RM && modrm[5:3] == xtad_pkg::MID_INC)
		begin
			d.cls = xtad_pkg::CL_INC;
			d.clk = reg_form ? xtad_pkg::CLK_INC_REG : xtad_pkg::CLK_INC_MEM + mem_ea;
		end
		else if (op[7:3] == xtad_pkg::PFX_INC_REG)
		begin
			d.cls = xtad_pkg::CL_INC;
			d.wide = 1'b1;
			d.mem = 1'b0;
			d.clk = xtad_pkg::CLK_INC_REG;
		end
		else
			d.legal = 1'b0;
		if (!d.legal)
		begin
			d.cls = xtad_pkg::CL_NONE;
			d.clk = 8'h01;
		end
		return d;
	endfunction

	always_comb
	begin
		xtad_dec_t d;
		xtad_alu_t r;
		logic [DATA_W-1:0] b;
		logic [DATA_W-1:0] f;
		logic [7:0] lo;
		logic [7:0] hi;
		logic fa;
		logic fc;
		next_st = st;
		next_st.done = 1'b0;
		d = decode(i_writedata[7:0], i_writedata[15:8], ea_clk, is_reg,
			i_writedata[xtad_pkg::INSTR_ODD]);
		b = st.opb;
		if (st.dec.data_bytes != 2'h0 && !st.dec.wide)
			b = {{(DATA_W-8){1'b0}}, st.opb[7:0]};
		else if (st.dec.data_bytes == 2'h1 && st.dec.wide)
			b = {{(DATA_W-8){st.opb[7]}}, st.opb[7:0]};
		unique case (st.dec.cls)
			xtad_pkg::CL_ADC: r = arith(st.opa, b, st.flags[xtad_pkg::FL_C], 1'b0, st.dec.wide);
			xtad_pkg::CL_SUB: r = arith(st.opa, b, 1'b0, 1'b1, st.dec.wide);
			xtad_pkg::CL_INC: r = arith(st.opa, {{(DATA_W-1){1'b0}}, 1'b1}, 1'b0, 1'b0,
				st.dec.wide);
			default: r = arith(st.opa, b, 1'b0, 1'b0, st.dec.wide);
		endcase
		f = szp(st.flags, r.sum[DATA_W-1:0], st.dec.wide);
		f[xtad_pkg::FL_C] = r.c;
		f[xtad_pkg::FL_A] = r.a;
		f[xtad_pkg::FL_O] = r.o;
		lo = st.opa[7:0];
		hi = st.opa[15:8];
		fa = (lo[3:0] > xtad_pkg::BCD_NINE) || st.flags[xtad_pkg::FL_A];
		fc = 1'b0;

		// Bus slave: one wait cycle, then answer
		if ((i_read || i_write) && st.bus_wait)
		begin
			next_st.bus_wait = 1'b0;
			unique case (i_address)
				xtad_pkg::OFS_INSTR: next_st.rdata = {15'h0000, st.instr};
				xtad_pkg::OFS_OPA: next_st.rdata = 32'(st.opa);
				xtad_pkg::OFS_OPB: next_st.rdata = 32'(st.opb);
				xtad_pkg::OFS_FLAGS: next_st.rdata = 32'(st.flags);
				xtad_pkg::OFS_STATUS: next_st.rdata = {st.dec.clk, 3'h0, st.dec.cls,
					6'h00, st.dec.data_bytes, st.seg_extra, st.dec.dir, st.dec.mem,
					st.dec.wide, st.refused, ~st.dec.legal, st.done, st.fsm == xtad_pkg::ST_BUSY};
				xtad_pkg::OFS_RESULT: next_st.rdata = 32'(st.result);
				xtad_pkg::OFS_SEG: next_st.rdata = 32'(st.seg);
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		else
			next_st.bus_wait = 1'b1;

		if (i_write && !st.bus_wait)
		begin
			unique case (i_address)
				xtad_pkg::OFS_INSTR:
				begin
					if (st.fsm == xtad_pkg::ST_BUSY)
						next_st.refused = 1'b1;
					else if (i_byteenable[0])
					begin
						next_st.instr = 17'(merge(32'(st.instr), i_writedata, i_byteenable));
						next_st.dec = d;
						next_st.cnt = d.clk;
						next_st.refused = 1'b0;
						next_st.fsm = xtad_pkg::ST_BUSY;
					end
				end
				xtad_pkg::OFS_OPA: next_st.opa = DATA_W'(merge(32'(st.opa), i_writedata, i_byteenable));
				xtad_pkg::OFS_OPB: next_st.opb = DATA_W'(merge(32'(st.opb), i_writedata, i_byteenable));
				xtad_pkg::OFS_FLAGS:
					if (st.fsm == xtad_pkg::ST_IDLE)
						next_st.flags = DATA_W'(merge(32'(st.flags), i_writedata, i_byteenable));
				default:
				begin
				end
			endcase
		end

		// Outcome committed when the count expires
		next_st.pend_res = r.sum[DATA_W-1:0];
		next_st.pend_flags = st.flags;
		unique case (st.dec.cls)
			xtad_pkg::CL_ADD, xtad_pkg::CL_ADC, xtad_pkg::CL_SUB, xtad_pkg::CL_INC:
				next_st.pend_flags = f;
			// offset and far-pointer word to register
			xtad_pkg::CL_OFFS_LOAD, xtad_pkg::CL_FAR_DS, xtad_pkg::CL_FAR_ES:
				next_st.pend_res = st.opb;
			xtad_pkg::CL_FL_STORE: next_st.pend_res = st.flags;
			xtad_pkg::CL_FL_RESTORE:
			begin
				next_st.pend_res = st.opb;
				next_st.pend_flags = st.opb;
			end
			xtad_pkg::CL_UBCD:
			begin
				if (fa)
				begin
					lo = lo + xtad_pkg::BCD_LOW_FIX;
					hi = hi + 8'h01;
				end
				next_st.pend_res = DATA_W'({hi, 4'h0, lo[3:0]});
				next_st.pend_flags[xtad_pkg::FL_A] = fa;
				next_st.pend_flags[xtad_pkg::FL_C] = fa;
			end
			xtad_pkg::CL_PBCD:
			begin
				fc = (lo > xtad_pkg::BCD_HIGH_LIM) || st.flags[xtad_pkg::FL_C];
				if (fa)
					lo = lo + xtad_pkg::BCD_LOW_FIX;
				if (fc)
					lo = lo + xtad_pkg::BCD_HIGH_FIX;
				next_st.pend_res = DATA_W'({hi, lo});
				next_st.pend_flags = szp(st.flags, DATA_W'(lo), 1'b0);
				next_st.pend_flags[xtad_pkg::FL_A] = fa;
				next_st.pend_flags[xtad_pkg::FL_C] = fc;
			end
			default:
			begin
			end
		endcase

		if (st.fsm == xtad_pkg::ST_BUSY)
		begin
			next_st.cnt = st.cnt - 8'h01;
			if (st.cnt == 8'h01)
			begin
				next_st.fsm = xtad_pkg::ST_IDLE;
				next_st.done = 1'b1;
				if (st.dec.legal)
				begin
					next_st.result = next_st.pend_res;
					next_st.flags = next_st.pend_flags;
				end
				if (st.dec.cls == xtad_pkg::CL_FAR_DS || st.dec.cls == xtad_pkg::CL_FAR_ES)
				begin
					next_st.seg = st.opa;
					next_st.seg_extra = (st.dec.cls == xtad_pkg::CL_FAR_ES);
				end
			end
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			st <= '0;
			st.fsm <= xtad_pkg::ST_IDLE;
			st.bus_wait <= 1'b1;
			st.flags <= xtad_pkg::FLAGS_RST;
			st.dec.cls <= xtad_pkg::CL_NONE;
		end
		else
			st <= next_st;
	end

	assign o_readdata = st.rdata;
	assign o_waitrequest = st.bus_wait;
	assign o_busy = st.fsm[1];
endmodule

/* sim/xtad_decode_assertions.sv */
`timescale 1ns/1ps
module xtad_decode_assertions #(
	parameter int DATA_W = 16
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [4:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	input wire logic o_busy
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);
	AST_RST: assert property (disable iff (1'b0)
		!i_nrst |=> o_waitrequest && !o_busy && o_readdata == 32'h0)
		else $error("Outputs not cleared by reset");
	AST_ANSWER: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
		else $error("Request not answered in one cycle");
	AST_WAIT_ONE: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("Answer longer than one cycle");
	AST_NO_SPUR: assert property (!o_waitrequest |-> $past(i_read || i_write))
		else $error("Answer without request");
	AST_BUSY_START: assert property (
		i_write && !o_waitrequest && i_address == xtad_pkg::OFS_INSTR
		&& i_byteenable[0] && !o_busy |=> o_busy)
		else $error("Instruction did not start");
	AST_BUSY_CAUSE: assert property ($rose(o_busy) |->
		$past(i_write && i_address == xtad_pkg::OFS_INSTR))
		else $error("Busy without instruction write");
	AST_BUSY_BOUND: assert property ($rose(o_busy) |-> ##[1:40] !o_busy)
		else $error("Busy too long");
	AST_UPPER_ZERO: assert property (
		!o_waitrequest && i_read && i_address == xtad_pkg::OFS_OPA
		|-> o_readdata[31:16] == 16'h0)
		else $error("Upper operand bits not zero");
	AST_UNMAPPED: assert property (
		!o_waitrequest && i_read && i_address > xtad_pkg::OFS_SEG |-> o_readdata == 32'h0)
		else $error("Unmapped read not zero");
endmodule

/* sim/xtad_imem.sv */
`timescale 1ns/1ps
module xtad_imem (
	input wire logic [4:0] i_idx,
	output logic [16:0] o_instr,
	output logic [7:0] o_clocks,
	output logic [4:0] o_class
);
	logic [29:0] ent;
	assign {o_instr, o_clocks, o_class} = ent;
	// Instruction, total clocks, class
	always_comb
	begin
		case (i_idx)
		5'h00: ent = {17'h1068D, 8'h08, 5'h01};
		5'h01: ent = {17'h007C5, 8'h15, 5'h02};
		5'h02: ent = {17'h100C4, 8'h1B, 5'h03};
		5'h03: ent = {17'h0009C, 8'h0A, 5'h04};
		5'h04: ent = {17'h0009D, 8'h08, 5'h05};
		5'h05: ent = {17'h14181, 8'h21, 5'h06};
		5'h06: ent = {17'h0C013, 8'h03, 5'h07};
		5'h07: ent = {17'h08412, 8'h12, 5'h07};
		5'h08: ent = {17'h00510, 8'h15, 5'h07};
		5'h09: ent = {17'h00015, 8'h04, 5'h07};
		5'h0A: ent = {17'h0C0FE, 8'h02, 5'h09};
		5'h0B: ent = {17'h004FF, 8'h14, 5'h09};
		5'h0C: ent = {17'h00037, 8'h04, 5'h0A};
		5'h0D: ent = {17'h00027, 8'h04, 5'h0B};
		5'h0E: ent = {17'h0C02B, 8'h03, 5'h08};
		5'h0F: ent = {17'h0E883, 8'h04, 5'h08};
		5'h10: ent = {17'h02E80, 8'h17, 5'h08};
		5'h11: ent = {17'h0C101, 8'h03, 5'h06};
		5'h12: ent = {17'h0002C, 8'h04, 5'h08};
		5'h13: ent = {17'h00043, 8'h02, 5'h09};
		5'h14: ent = {17'h11683, 8'h1B, 5'h07};
		5'h15: ent = {17'h00005, 8'h04, 5'h06};
		default: ent = {17'h000F4, 8'h01, 5'h00};
		endcase
	end
endmodule

/* sim/tb_x16_transfer_arith_decode.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
	begin \
		compares++; \
		if ((ex) !== (gt)) \
		begin \
			failures++; \
			$display("ERROR %s expected %h seen %h", nm, ex, gt); \
		end \
	end
module tb_x16_transfer_arith_decode;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [4:0] i_address = 5'h00;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [3:0] i_byteenable = 4'hF;
	logic [31:0] o_readdata;
	logic o_waitrequest;
	logic o_busy;
	logic [4:0] idx = 5'h00;
	logic [16:0] t_instr;
	logic [7:0] t_clk;
	logic [4:0] t_cls;
	logic [31:0] rd;
	int failures = 0;
	int compares = 0;
	int n;
	xtad_decode #(.DATA_W(16)) u_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_busy(o_busy));
	xtad_imem u_mem (.i_idx(idx), .o_instr(t_instr), .o_clocks(t_clk), .o_class(t_cls));
	initial
	begin
		forever #5 i_ref_clk = ~i_ref_clk;
	end
	task end_sim;
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wait_ans;
		int k;
		for (k = 0; k < 50; k++)
		begin
			@(posedge i_ref_clk);
			if (o_waitrequest === 1'b0)
				break;
		end
		if (k == 50)
		begin
			failures++;
			end_sim;
		end
	endtask
	task bus_wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge i_ref_clk);
		i_address <= a;
		i_writedata <= d;
		i_write <= 1'b1;
		wait_ans;
		i_write <= 1'b0;
	endtask
	task bus_rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge i_ref_clk);
		i_address <= a;
		i_read <= 1'b1;
		wait_ans;
		d = o_readdata;
		i_read <= 1'b0;
	endtask
	// Counts busy cycles into n
	task wait_idle;
		int k;
		n = 0;
		for (k = 0; k < 100; k++)
		begin
			@(posedge i_ref_clk);
			if (o_busy !== 1'b1)
				break;
			n++;
		end
		if (k == 100)
		begin
			failures++;
			end_sim;
		end
	endtask
	task run(input logic [16:0] ins, input logic [15:0] a, input logic [15:0] b);
		bus_wr(xtad_pkg::OFS_OPA, {16'h0, a});
		bus_wr(xtad_pkg::OFS_OPB, {16'h0, b});
		bus_wr(xtad_pkg::OFS_INSTR, {15'h0, ins});
		wait_idle;
	endtask
	task t_table;
		int i;
		for (i = 0; i < 23; i++)
		begin
			idx = i[4:0];
			#1;
			run(t_instr, 16'h1234, 16'h0F0F);
			`CHK("busy cycles", t_clk, n[7:0])
			bus_rd(xtad_pkg::OFS_STATUS, rd);
			`CHK("total clocks", t_clk, rd[31:24])
			`CHK("class", t_cls, rd[20:16])
			`CHK("illegal", (i == 22), rd[2])
			if (i inside {[5:11], [14:21]})
				`CHK("word", t_instr[0], rd[4])
			if (i inside {[6:8], 14, 17})
				`CHK("direction", t_instr[1], rd[6])
			if (i == 5 || i == 15 || i == 20)
				`CHK("imm bytes", (t_instr[1:0] == 2'b01) ? 2'h2 : 2'h1, rd[9:8])
		end
	endtask
	task t_arith;
		bus_wr(xtad_pkg::OFS_FLAGS, 32'h0);
		run(17'h14181, 16'h1234, 16'h0F0F);
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("add result", 32'h2143, rd)
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("add flags", 32'h0010, rd)
		bus_wr(xtad_pkg::OFS_FLAGS, 32'h0);
		run(17'h0C02B, 16'h0001, 16'h0002);
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("sub result", 32'hFFFF, rd)
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("sub flags", 32'h0095, rd)
		bus_wr(xtad_pkg::OFS_FLAGS, 32'h0);
		run(17'h00027, 16'h000A, 16'h0000);
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("packed result", 8'h10, rd[7:0])
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("packed flags", 32'h0010, rd)
		bus_wr(xtad_pkg::OFS_FLAGS, 32'h0);
		run(17'h00037, 16'h010B, 16'h0000);
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("unpacked result", 32'h0201, rd)
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("unpacked flags", 32'h0011, rd)
	endtask
	task t_xfer;
		run(17'h0009D, 16'h0000, 16'h08D5);
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("restored flags", 32'h08D5, rd)
		run(17'h0009C, 16'h0000, 16'h0000);
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("stored flags", 32'h08D5, rd)
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("pushed word", 32'h08D5, rd)
		run(17'h007C5, 16'hBEEF, 16'h0F0F);
		bus_rd(xtad_pkg::OFS_SEG, rd);
		`CHK("segment", 32'hBEEF, rd)
		bus_rd(xtad_pkg::OFS_STATUS, rd);
		`CHK("seg is data", 1'b0, rd[7])
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("pointer offset", 32'h0F0F, rd)
		run(17'h000C4, 16'h1357, 16'h2468);
		bus_rd(xtad_pkg::OFS_SEG, rd);
		`CHK("extra segment", 32'h1357, rd)
		bus_rd(xtad_pkg::OFS_STATUS, rd);
		`CHK("seg is extra", 1'b1, rd[7])
		`CHK("far clocks", 8'h17, rd[31:24])
		run(17'h0068D, 16'h0000, 16'h0F0F);
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("offset", 32'h0F0F, rd)
	endtask
	task t_refuse;
		bus_wr(xtad_pkg::OFS_FLAGS, 32'h0);
		bus_wr(xtad_pkg::OFS_OPA, 32'h0001);
		bus_wr(xtad_pkg::OFS_INSTR, 32'h004FF);
		bus_wr(xtad_pkg::OFS_INSTR, 32'h00037);
		bus_wr(xtad_pkg::OFS_FLAGS, 32'hFFFF);
		bus_rd(xtad_pkg::OFS_STATUS, rd);
		`CHK("busy bit", 1'b1, rd[0])
		`CHK("refused", 1'b1, rd[3])
		`CHK("kept class", 5'h09, rd[20:16])
		wait_idle;
		bus_rd(xtad_pkg::OFS_FLAGS, rd);
		`CHK("inc flags", 32'h0, rd)
		bus_rd(xtad_pkg::OFS_RESULT, rd);
		`CHK("inc result", 32'h0002, rd)
		i_byteenable <= 4'h0;
		bus_wr(xtad_pkg::OFS_INSTR, 32'h00037);
		i_byteenable <= 4'hF;
		bus_rd(xtad_pkg::OFS_STATUS, rd);
		`CHK("lane0 off idle", 1'b0, rd[0])
		`CHK("lane0 off class", 5'h09, rd[20:16])
		bus_rd(5'h1C, rd);
		`CHK("unmapped", 32'h0, rd)
	endtask
	initial
	begin
		repeat (16) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		t_table;
		t_arith;
		t_xfer;
		t_refuse;
		end_sim;
	end
endmodule
bind xtad_decode xtad_decode_assertions #(.DATA_W(DATA_W)) u_ast (.i_ref_clk(i_ref_clk),
	.i_nrst(i_nrst), .i_address(i_address), .i_read(i_read), .i_write(i_write),
	.i_writedata(i_writedata), .i_byteenable(i_byteenable), .o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest), .o_busy(o_busy));
